// [shared/smcd_pkg.sv]
// package for the switch monitor command decoder: opcodes, fields, timing
package smcd_pkg;

   // serial frame
   localparam int          CMD_W      = 16;
   localparam int          FIELD_W    = 12;
   localparam int          TEST_BIT   = 15;
   localparam int          OPC_LSB    = 12;
   localparam logic [4:0]  FRAME_BITS = 5'h10;
   localparam logic [4:0]  FRAME_OVER = 5'h11;

   // top-nibble opcodes; every other nibble with a clear top bit does nothing
   localparam logic [3:0]  OPC_SLEEP  = 4'h0;
   localparam logic [3:0]  OPC_RUN    = 4'h1;
   localparam logic [3:0]  OPC_DIS    = 4'h3;
   localparam logic [3:0]  OPC_MET    = 4'h5;

   // reset values of the three configuration registers, and the response pad
   localparam logic [11:0] RUN_RESET  = 12'h000;
   localparam logic [11:0] DIS_RESET  = 12'h000;
   localparam logic [11:0] MET_RESET  = 12'h000;
   localparam logic [1:0]  RSP_PAD    = 2'h0;

   // timing
   localparam int CLK_PERIOD_NS   = 50;
   localparam int SENSE_PERIOD_NS = 4800000;
   localparam int WAKE_BASE_NS    = 2800000;
   localparam int SENSE_CYC_DEF   = SENSE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int WAKE_CYC_DEF    = WAKE_BASE_NS / CLK_PERIOD_NS;

   // operating mode; codes equal the operating_select field
   typedef enum logic [1:0] {
      MODE_SLEEP    = 2'h0,
      MODE_NORMAL   = 2'h1,
      MODE_POLL     = 2'h2,
      MODE_POLL_TMR = 2'h3
   } smcd_mode_e;

   // polling phase, gray along idle -> on -> off
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_ON   = 2'h1,
      PH_OFF  = 2'h3
   } smcd_phase_e;

   typedef struct packed {
      logic [1:0] operating_select;
      logic [2:0] off_interval_sel;
      logic       spare;
      logic [1:0] wake_period_sel;
      logic [3:0] prog_input_polarity;
   } smcd_run_s;

   typedef struct packed {
      logic [5:0] ground;
      logic [3:0] prog;
      logic [1:0] battery;
   } smcd_inputs_s;

   // off interval in base sense periods
   function automatic logic [5:0] off_mult(input logic [2:0] sel);
      case (sel)
         3'h0:    off_mult = 6'h05;
         3'h1:    off_mult = 6'h09;
         3'h2:    off_mult = 6'h11;
         3'h3:    off_mult = 6'h19;
         3'h4:    off_mult = 6'h21;
         3'h5:    off_mult = 6'h29;
         3'h6:    off_mult = 6'h31;
         default: off_mult = 6'h39;
      endcase
   endfunction

   // wake interval in wake base periods
   function automatic logic [9:0] wake_mult(input logic [1:0] sel);
      case (sel)
         2'h0:    wake_mult = 10'h201;
         2'h1:    wake_mult = 10'h101;
         2'h2:    wake_mult = 10'h081;
         default: wake_mult = 10'h041;
      endcase
   endfunction

endpackage

// [hdl/smcd_sync.sv]
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module smcd_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // meta_q feeds only the second stage; reset to the idle levels so no false edge follows reset
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         meta_q   <= RST;
         sync_out <= RST;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// [hdl/smcd_top.sv]
// switch monitor command decoder: serial slave, configuration registers, polling timers
`timescale 1ns/1ps
module smcd_top #(
   parameter int SENSE_CYC = smcd_pkg::SENSE_CYC_DEF,
   parameter int WAKE_CYC  = smcd_pkg::WAKE_CYC_DEF
) (
   input  wire logic               core_clk,
   input  wire logic               nrst,
   input  wire logic               spi_sclk,
   input  wire logic               spi_cs_n,
   input  wire logic               spi_si,
   output logic                    spi_so,
   output logic                    spi_so_oe_n,
   output smcd_pkg::smcd_mode_e    op_mode,
   output logic                    test_mode,
   output logic                    blocks_on,
   output smcd_pkg::smcd_inputs_s  current_en,
   output smcd_pkg::smcd_inputs_s  comparator_en,
   output smcd_pkg::smcd_inputs_s  wetting_en,
   output logic [3:0]              prog_input_polarity,
   output logic                    wake_irq_n
);
   localparam int PW = $clog2(SENSE_CYC + 1);
   localparam int WW = $clog2(WAKE_CYC + 1);
   localparam logic [2:0] PIN_IDLE = 3'h2; // clock low, select high, data low

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic s_sclk;
   logic s_cs_n;
   logic s_si;

   smcd_sync #(.W(3), .RST(PIN_IDLE)) u_sync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .async_in ({spi_sclk, spi_cs_n, spi_si}),
      .sync_out ({s_sclk, s_cs_n, s_si})
   );

   ////////////////////////////////////////////////////////////////////////////
   // serial shifter

   logic                  sclk_prev_q;
   logic                  cs_prev_q;
   logic [15:0]           rx_q;
   logic [15:0]           tx_q;
   logic [4:0]            bit_cnt_q;
   logic                  oe_n_q;
   smcd_pkg::smcd_mode_e  mode_q;
   smcd_pkg::smcd_run_s   run_q;
   smcd_pkg::smcd_inputs_s en_mask_q;
   smcd_pkg::smcd_inputs_s metal_q;
   logic                  test_q;

   // edges seen on the sampled link clock and select
   wire sclk_rise = s_sclk & ~sclk_prev_q;
   wire sclk_fall = ~s_sclk & sclk_prev_q;
   wire cs_fall   = ~s_cs_n & cs_prev_q;
   wire cs_rise   = s_cs_n & ~cs_prev_q;
   wire in_frame  = ~s_cs_n;
   wire cnt_full  = (bit_cnt_q == smcd_pkg::FRAME_OVER);

   // response word: mode code, pad, current enable mask
   wire [15:0] status_word = {mode_q, smcd_pkg::RSP_PAD, en_mask_q};

   // a frame counts only when select rises after exactly sixteen clocks
   wire cmd_valid = cs_rise & (bit_cnt_q == smcd_pkg::FRAME_BITS);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= s_sclk;
         cs_prev_q   <= s_cs_n;
      end
   end

   // receive msb first on rising clock; a 17th clock marks the frame bad
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rx_q      <= 16'h0000;
         bit_cnt_q <= 5'h00;
      end else if (cs_fall) begin
         bit_cnt_q <= 5'h00;
      end else if (in_frame && sclk_rise && !cnt_full) begin
         rx_q      <= {rx_q[14:0], s_si};
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   // transmit: load on select fall, advance on falling clock
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tx_q   <= 16'h0000;
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= s_cs_n;
         if (cs_fall) begin
            tx_q <= status_word;
         end else if (in_frame && sclk_fall) begin
            tx_q <= {tx_q[14:0], 1'b0};
         end
      end
   end

   assign spi_so      = tx_q[15];
   assign spi_so_oe_n = oe_n_q; // released whenever select is high

   ////////////////////////////////////////////////////////////////////////////
   // command decode

   wire [3:0]            opc      = rx_q[15:smcd_pkg::OPC_LSB];
   wire [11:0]           field    = rx_q[11:0];
   smcd_pkg::smcd_run_s  run_word;
   assign run_word = field;

   // the top bit overrides any opcode; unlisted nibbles fall through to nothing
   wire is_test  = cmd_valid & rx_q[smcd_pkg::TEST_BIT];
   wire is_run   = cmd_valid & (opc == smcd_pkg::OPC_RUN);
   wire is_dis   = cmd_valid & (opc == smcd_pkg::OPC_DIS);
   wire is_met   = cmd_valid & (opc == smcd_pkg::OPC_MET);
   wire is_sleep = cmd_valid & (opc == smcd_pkg::OPC_SLEEP);
   wire nonfunc  = cmd_valid & ~rx_q[smcd_pkg::TEST_BIT] & ~is_run & ~is_dis & ~is_met & ~is_sleep;

   // run word: 00 in operating_select keeps the mode but polarity still lands
   wire sel_defined = (run_word.operating_select != 2'h0);
   wire mode_load   = is_run & sel_defined;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mode_q <= smcd_pkg::MODE_SLEEP;
         test_q <= 1'b0;
      end else begin
         if (mode_load) begin
            mode_q <= smcd_pkg::smcd_mode_e'(run_word.operating_select);
         end else if (is_sleep) begin
            mode_q <= smcd_pkg::MODE_SLEEP;
         end
         if (is_test) begin
            test_q <= 1'b1;
         end else if (is_run || is_dis || is_met || is_sleep) begin
            test_q <= 1'b0;
         end
      end
   end

   // configuration registers; disable and metallic leave the mode alone
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         run_q     <= smcd_pkg::RUN_RESET;
         en_mask_q <= smcd_pkg::DIS_RESET;
         metal_q   <= smcd_pkg::MET_RESET;
      end else begin
         if (is_run) begin
            run_q <= run_word;
         end
         if (is_dis) begin
            en_mask_q <= field;
         end
         if (is_met) begin
            metal_q <= field;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // polling sequencer: one sense period on, multiplier periods off

   smcd_pkg::smcd_phase_e phase_q;
   logic [PW-1:0]         pre_q;
   logic [5:0]            off_cnt_q;

   wire polling   = (mode_q == smcd_pkg::MODE_POLL) | (mode_q == smcd_pkg::MODE_POLL_TMR);
   wire sense_tk  = polling & (pre_q == PW'(SENSE_CYC - 1));
   wire [5:0] off_limit = smcd_pkg::off_mult(run_q.off_interval_sel);
   wire off_done  = sense_tk & (off_cnt_q == off_limit - 6'h01);

   // prescaler free-runs in polling; zero otherwise so each entry starts clean
   always_ff @(posedge core_clk) begin
      if (!nrst || !polling || sense_tk || is_run) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + PW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         phase_q   <= smcd_pkg::PH_IDLE;
         off_cnt_q <= 6'h00;
      end else if (!polling || is_run) begin
         // a run word restarts the sequence so a new multiplier never meets a count past it
         phase_q   <= smcd_pkg::PH_IDLE;
         off_cnt_q <= 6'h00;
      end else begin
         case (phase_q)
            smcd_pkg::PH_IDLE: phase_q <= smcd_pkg::PH_ON;
            smcd_pkg::PH_ON: begin
               if (sense_tk) begin
                  phase_q   <= smcd_pkg::PH_OFF;
                  off_cnt_q <= 6'h00;
               end
            end
            smcd_pkg::PH_OFF: begin
               if (off_done) begin
                  phase_q <= smcd_pkg::PH_ON;
               end else if (sense_tk) begin
                  off_cnt_q <= off_cnt_q + 6'h01;
               end
            end
            default: phase_q <= smcd_pkg::PH_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wake-up timer, only counts in polling with timer

   logic [WW-1:0] wpre_q;
   logic [9:0]    wake_cnt_q;
   logic          wake_q;

   wire timer_mode = (mode_q == smcd_pkg::MODE_POLL_TMR);
   wire wake_tk    = timer_mode & (wpre_q == WW'(WAKE_CYC - 1));
   wire [9:0] wake_limit = smcd_pkg::wake_mult(run_q.wake_period_sel);
   wire wake_fire  = wake_tk & (wake_cnt_q == wake_limit - 10'h001);

   always_ff @(posedge core_clk) begin
      if (!nrst || !timer_mode || wake_tk || is_run) begin
         wpre_q <= '0;
      end else begin
         wpre_q <= wpre_q + WW'(1);
      end
   end

   // interrupt stays low until the next good frame; a new fire beats the clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wake_cnt_q <= 10'h000;
         wake_q     <= 1'b0;
      end else begin
         if (!timer_mode || wake_fire || is_run) begin
            wake_cnt_q <= 10'h000;
         end else if (wake_tk) begin
            wake_cnt_q <= wake_cnt_q + 10'h001;
         end
         if (wake_fire) begin
            wake_q <= 1'b1;
         end else if (cmd_valid) begin
            wake_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs to the analog input blocks

   wire awake = (mode_q != smcd_pkg::MODE_SLEEP);
   // in sleep everything is off; comparators stay attached even when an input is disabled
   assign blocks_on     = awake & (!polling | (phase_q == smcd_pkg::PH_ON));
   assign current_en    = en_mask_q & {12{blocks_on}};
   assign comparator_en = {12{blocks_on}};
   assign wetting_en    = current_en & metal_q;
   assign prog_input_polarity = run_q.prog_input_polarity;
   assign op_mode    = mode_q;
   assign test_mode  = test_q;
   assign wake_irq_n = ~wake_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   int unsigned off_len_h;
   always_ff @(posedge core_clk) begin
      if (!nrst || phase_q != smcd_pkg::PH_OFF) begin
         off_len_h <= 0;
      end else begin
         off_len_h <= off_len_h + 1;
      end
   end

   sequence run_taken;
      is_run && sel_defined;
   endsequence

   bad_frame_a: assert property (cs_rise && bit_cnt_q != smcd_pkg::FRAME_BITS |=>
      $stable(run_q) && $stable(en_mask_q) && $stable(metal_q) && $stable(mode_q))
      else $error("short or long frame changed state");
   run_store_a: assert property (is_run |=> run_q == $past(field))
      else $error("run word not stored");
   mode_pick_a: assert property (run_taken |=> mode_q == $past(field[11:10]))
      else $error("run did not set mode");
   undef_keep_a: assert property (is_run && !sel_defined |=> $stable(mode_q) &&
      prog_input_polarity == $past(field[3:0]))
      else $error("undefined select changed mode");
   dis_mode_a: assert property (is_dis |=> $stable(mode_q) && en_mask_q == $past(field))
      else $error("disable command disturbed mode");
   met_mode_a: assert property (is_met |=> $stable(mode_q) && metal_q == $past(field))
      else $error("metallic command disturbed mode");
   test_enter_a: assert property (is_test |=> test_mode && $stable(en_mask_q) && $stable(mode_q))
      else $error("test bit ignored");
   nonfunc_a: assert property (nonfunc |=> $stable(run_q) && $stable(en_mask_q) &&
      $stable(metal_q) && $stable(mode_q) && $stable(test_q))
      else $error("non-functional opcode acted");
   off_quiet_a: assert property (phase_q == smcd_pkg::PH_OFF |-> !blocks_on && current_en == 12'h000)
      else $error("inputs powered during off time");
   off_len_a: assert property (phase_q == smcd_pkg::PH_OFF ##1 phase_q == smcd_pkg::PH_ON |->
      $past(off_len_h) + 1 == off_limit * SENSE_CYC)
      else $error("off interval length wrong");
   cur_gate_a: assert property (blocks_on |-> current_en == en_mask_q && comparator_en == 12'hfff)
      else $error("current gating wrong");
   wake_src_a: assert property ($fell(wake_irq_n) |-> $past(timer_mode) && $past(wake_fire))
      else $error("wake interrupt outside timer mode");
   wet_gate_a: assert property (wetting_en == (blocks_on ? (en_mask_q & metal_q) : 12'h000))
      else $error("wetting pulse without metallic bit");
   mask_reset_a: assert property (@(posedge core_clk) disable iff (1'b0)
      !nrst |=> en_mask_q == 12'h000 && mode_q == smcd_pkg::MODE_SLEEP)
      else $error("reset left inputs enabled");

endmodule

// [test/smcd_host.sv]
// host-side serial master model that drives the command link of the decoder
`timescale 1ns/1ps
module smcd_host (
   input  wire logic spi_so,
   input  wire logic spi_so_oe_n,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_si
);
   localparam int HALF = 200;  // half of the 400 ns link clock

   // link idles with clock low and select high
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_si   = 1'b0;
   end

   // data line is not held between frames: toggle it so a stale bit never looks like data
   always #100 if (spi_cs_n) spi_si = ~spi_si;

   //////////////////////////////////////////////////////////////////////////////
   // one frame of nbits clocks, msb first; clocks past sixteen carry junk
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rsp);
      rsp      = 16'h0000;
      spi_cs_n = 1'b0;
      #HALF;
      for (int i = 0; i < nbits; i++) begin
         spi_si = (i < 16) ? w[15 - (i % 16)] : ~w[0];
         #HALF;
         spi_sclk = 1'b1;
         rsp      = {rsp[14:0], spi_so_oe_n ? ~spi_so : spi_so};  // a released line reads inverted
         #HALF;
         spi_sclk = 1'b0;
      end
      #HALF;
      spi_cs_n = 1'b1;
      #(3 * HALF);  // select stays high well past the decoder's minimum gap
   endtask
endmodule

// [test/switch_monitor_cmd_decode_bench.sv]
// self-checking bench for the switch monitor command decoder
`timescale 1ns/1ps
module switch_monitor_cmd_decode_bench;
   localparam int SC = 8;  // shortened sense period
   localparam int WC = 4;  // shortened wake base period

   logic                   core_clk;
   logic                   nrst;
   logic                   spi_sclk;
   logic                   spi_cs_n;
   logic                   spi_si;
   logic                   spi_so;
   logic                   spi_so_oe_n;
   logic                   test_mode;
   logic                   blocks_on;
   logic                   wake_irq_n;
   logic [3:0]             prog_input_polarity;
   logic [15:0]            rsp;
   smcd_pkg::smcd_mode_e   op_mode;
   smcd_pkg::smcd_inputs_s current_en;
   smcd_pkg::smcd_inputs_s comparator_en;
   smcd_pkg::smcd_inputs_s wetting_en;
   int                     fail_count;
   int                     checked;
   int                     m_mode;
   int                     m_test;
   int                     m_pol;
   int                     m_dis;
   int                     m_met;
   int                     offm [8] = '{5, 9, 17, 25, 33, 41, 49, 57};
   int                     wkm [4]  = '{513, 257, 129, 65};

   smcd_top #(.SENSE_CYC(SC), .WAKE_CYC(WC)) DUT (
      .core_clk(core_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .op_mode(op_mode), .test_mode(test_mode),
      .blocks_on(blocks_on), .current_en(current_en), .comparator_en(comparator_en),
      .wetting_en(wetting_en), .prog_input_polarity(prog_input_polarity), .wake_irq_n(wake_irq_n)
   );

   smcd_host host (
      .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si)
   );

   // 20 MHz core clock
   always #25 core_clk = ~core_clk;

   //////////////////////////////////////////////////////////////////////////////
   // verdict and compare tasks
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic timeout();
      fail_count++;
      $display("CHECK FAILED t=%0t wait bound ran out", $time);
      test_done();
   endtask

   task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_rsp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t response got=%h exp=%h", $time, got, exp);
      end
   endtask

   // measured cycle counts may trail the real start by the link latency, hence tol
   task automatic chk_time(input int got, input int exp, input int tol);
      checked++;
      if (got < exp - tol || got > exp + tol) begin
         fail_count++;
         $display("CHECK FAILED t=%0t cycles got=%h exp=%h", $time, got, exp);
      end
   endtask

   //////////////////////////////////////////////////////////////////////////////
   // reference model of the configuration state
   task automatic model(input logic [15:0] w);
      if (w[15:12] inside {4'h0, 4'h1, 4'h3, 4'h5}) begin
         m_test = 0;
      end
      case (w[15:12])
         4'h0: m_mode = 0;
         4'h1: begin
            if (w[11:10] != 2'h0) begin
               m_mode = w[11:10];
            end
            m_pol = w[3:0];
         end
         4'h3: m_dis = w[11:0];
         4'h5: m_met = w[11:0];
         default: begin
            if (w[15]) begin
               m_test = 1;
            end
         end
      endcase
   endtask

   // enables are only predictable outside polling and test mode
   task automatic chk_outs();
      logic [11:0] cur;
      cur = (m_mode == 1) ? m_dis[11:0] : 12'h000;
      chk_cfg({14'h0, op_mode}, m_mode[15:0]);
      chk_cfg({15'h0, test_mode}, m_test[15:0]);
      chk_cfg({12'h0, prog_input_polarity}, m_pol[15:0]);
      if (m_test == 0 && m_mode < 2) begin
         chk_cfg({4'h0, current_en}, {4'h0, cur});
         chk_cfg({4'h0, comparator_en}, (m_mode == 1) ? 16'h0fff : 16'h0000);
         chk_cfg({4'h0, wetting_en}, {4'h0, cur & m_met[11:0]});
      end
   endtask

   task automatic cmd(input logic [15:0] w);
      logic [15:0] exp_rsp;
      exp_rsp = {m_mode[1:0], 2'h0, m_dis[11:0]};
      host.xfer(w, 16, rsp);
      chk_rsp(rsp, exp_rsp);
      chk_cfg({15'h0, spi_so_oe_n}, 16'h0001);
      model(w);
      chk_outs();
   endtask

   task automatic do_reset(input int cyc);
      nrst   = 1'b0;
      m_mode = 0;
      m_test = 0;
      m_pol  = 0;
      m_dis  = 0;
      m_met  = 0;
      repeat (cyc) @(negedge core_clk);
      nrst = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask

   //////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int n;
      core_clk   = 1'b0;
      nrst       = 1'b0;
      fail_count = 0;
      checked    = 0;
      void'($urandom(32'h2523cc5d));
      do_reset(8);
      chk_outs();
      chk_cfg({14'h0, spi_so_oe_n, wake_irq_n}, 16'h0003);
      cmd({4'h3, 12'($urandom)});
      cmd({4'h5, 12'($urandom)});
      cmd({4'h1, 2'h1, 10'($urandom)});
      repeat (4) begin
         cmd({4'h3, 12'($urandom)});
         cmd({4'h5, 12'($urandom)});
      end
      foreach (offm[i]) cmd({1'b0, 3'(i + 2), 12'($urandom)});
      host.xfer({4'h3, 12'($urandom)}, 15, rsp);
      chk_outs();
      host.xfer({4'h3, 12'($urandom)}, 17, rsp);
      chk_outs();
      cmd({4'h1, 2'h0, 10'($urandom)});
      cmd({1'b1, 15'($urandom)});
      cmd({1'b1, 15'($urandom)});
      cmd(16'h0000);
      // polling: time each off interval against its multiplier
      for (int s = 0; s < 8; s++) begin
         cmd({4'h1, 2'h1, 10'($urandom)});
         cmd({4'h1, 2'h2, 3'(s), 7'($urandom)});
         // skip the rest of the first off interval, then the next on time
         n = 0;
         while (blocks_on === 1'b0 && n < 1000) begin
            @(negedge core_clk);
            n++;
         end
         if (n == 1000) timeout();
         n = 0;
         while (blocks_on !== 1'b0 && n < 100) begin
            @(negedge core_clk);
            n++;
         end
         if (n == 100) timeout();
         n = 0;
         while (blocks_on === 1'b0 && n < 1000) begin
            if (n == 1) chk_cfg({4'h0, comparator_en}, 16'h0000);
            @(negedge core_clk);
            n++;
         end
         chk_time(n, offm[s] * SC, 0);
      end
      // timer mode: time the first wake pulse, then see a frame release it
      for (int w = 0; w < 4; w++) begin
         cmd({4'h1, 2'h1, 10'($urandom)});
         cmd({4'h1, 2'h3, 4'($urandom), 2'(w), 4'($urandom)});
         n = 0;
         while (wake_irq_n !== 1'b0 && n < 3000) begin
            @(negedge core_clk);
            n++;
         end
         if (n == 3000) timeout();
         // timing starts 12 cycles after select rises; the frame lands and counting starts 3 cycles after that rise
         chk_time(n, wkm[w] * WC - 9, 2);
         cmd({4'h1, 2'h1, 10'($urandom)});
         chk_cfg({15'h0, wake_irq_n}, 16'h0001);
      end
      // reset in mid-run clears the mask
      cmd(16'h3fff);
      do_reset(3);
      chk_outs();
      cmd({4'h3, 12'($urandom)});
      test_done();
   end
endmodule
